// ===== hdl/csp_status_pins.sv
// Charger status pin logic: register port, pin indicators, charge gating and host alert.
`timescale 1ns/1ps
module csp_status_pins
	import csp_pkg::*;
#(
	parameter int unsigned P_ALERT_CYCLES = ALERT_PULSE_CYCLES
) (
	input  wire logic               i_clk,
	input  wire logic               i_reset_n,
	input  wire logic [7:0]         i_addr,
	input  wire logic [31:0]        i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output logic      [31:0]        o_rdata,
	input  wire logic [1:0]         i_charger_state,
	input  wire logic [VOLT_W-1:0]  i_adapter_voltage,
	input  wire logic               i_thermistor_input_fault,
	input  wire logic [LIMIT_W-1:0] i_charge_limit_pin,
	input  wire logic [LIMIT_W-1:0] i_input_limit_pin,
	input  wire logic               i_input_limit_pin_high,
	input  wire logic               i_charge_enable_pin_n,
	output logic                    o_charge_enable_pin_o,
	output logic                    o_charge_enable_pin_oe,
	output logic                    o_status_out_one_o,
	output logic                    o_status_out_one_oe,
	output logic                    o_status_out_two_o,
	output logic                    o_status_out_two_oe,
	output logic                    o_input_good_n_o,
	output logic                    o_input_good_n_oe,
	output logic                    o_host_alert_o,
	output logic                    o_host_alert_oe,
	output logic                    o_irq,
	output logic                    o_charge_allowed,
	output logic                    o_input_high_impedance_state,
	output logic      [LIMIT_W-1:0] o_charge_limit,
	output logic      [LIMIT_W-1:0] o_input_limit
);
	logic [CTRL_W-1:0]  ctrl_r;
	logic [LIMIT_W-1:0] chg_limit_r;
	logic [LIMIT_W-1:0] in_limit_r;
	logic [VOLT_W-1:0]  uv_limit_r;
	logic [VOLT_W-1:0]  ov_limit_r;
	logic [EV_W-1:0]    int_status_r;
	logic [EV_W-1:0]    int_enable_r;
	logic [EV_W-1:0]    int_clear;
	logic [EV_W-1:0]    events;
	logic [SYNC_W-1:0]  async_in;
	logic [SYNC_W-1:0]  sync1_r;
	logic [SYNC_W-1:0]  sync2_r;
	logic [SYNC_W-1:0]  sync3_r;
	logic [SYNC_W-1:0]  pin_r;
	logic [3:0]         force_on;
	logic               input_good;
	logic               input_high_impedance_state;
	logic               charge_allowed_nxt;
	logic [1:0]         prev_state_r;
	logic               prev_good_r;
	logic               prev_therm_r;
	logic               prev_hiz_r;
	logic               armed_r;
	logic [31:0]        rdata_nxt;

	assign async_in = {i_charge_enable_pin_n, i_input_limit_pin_high, i_thermistor_input_fault};
	assign force_on = ctrl_r[CTRL_FORCE_LSB +: 4];

	// Pin inputs pass three flops; a new level is taken once the last two agree.
	for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
		always_ff @(posedge i_clk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				sync1_r[g] <= SYNC_RST[g];
				sync2_r[g] <= SYNC_RST[g];
				sync3_r[g] <= SYNC_RST[g];
				pin_r[g]   <= SYNC_RST[g];
			end else begin
				sync1_r[g] <= async_in[g];
				sync2_r[g] <= sync1_r[g];
				sync3_r[g] <= sync2_r[g];
				if (sync2_r[g] == sync3_r[g]) begin
					pin_r[g] <= sync3_r[g];
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_r      <= CTRL_RST;
			chg_limit_r <= CHG_LIMIT_RST;
			in_limit_r  <= IN_LIMIT_RST;
			uv_limit_r  <= UV_LIMIT_RST;
			ov_limit_r  <= OV_LIMIT_RST;
		end else if (i_wr) begin
			case (i_addr)
				ADDR_CTRL:      ctrl_r      <= i_wdata[CTRL_W-1:0];
				ADDR_CHG_LIMIT: chg_limit_r <= i_wdata[LIMIT_W-1:0];
				ADDR_IN_LIMIT:  in_limit_r  <= i_wdata[LIMIT_W-1:0];
				ADDR_UV_LIMIT:  uv_limit_r  <= i_wdata[VOLT_W-1:0];
				ADDR_OV_LIMIT:  ov_limit_r  <= i_wdata[VOLT_W-1:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			int_enable_r <= INT_EN_RST;
		end else if (i_wr && i_addr == ADDR_INT_ENABLE) begin
			int_enable_r <= i_wdata[EV_W-1:0];
		end
	end

	assign int_clear = (i_wr && i_addr == ADDR_INT_CLEAR) ? i_wdata[EV_W-1:0] : '0;

	// A new event wins over a clear written in the same cycle.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			int_status_r <= '0;
		end else begin
			int_status_r <= (int_status_r & ~int_clear) | events;
		end
	end

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (i_addr)
			ADDR_CTRL:       rdata_nxt[CTRL_W-1:0]  = ctrl_r;
			ADDR_CHG_LIMIT:  rdata_nxt[LIMIT_W-1:0] = chg_limit_r;
			ADDR_IN_LIMIT:   rdata_nxt[LIMIT_W-1:0] = in_limit_r;
			ADDR_UV_LIMIT:   rdata_nxt[VOLT_W-1:0]  = uv_limit_r;
			ADDR_OV_LIMIT:   rdata_nxt[VOLT_W-1:0]  = ov_limit_r;
			ADDR_STATE:      rdata_nxt[7:0] = {o_input_high_impedance_state, o_charge_allowed,
				pin_r[SYNC_CE], pin_r[SYNC_THERM], input_good, i_charger_state, input_high_impedance_state};
			ADDR_EFF_LIMITS: rdata_nxt[15:0] = {o_input_limit, o_charge_limit};
			ADDR_INT_STATUS: rdata_nxt[EV_W-1:0] = int_status_r;
			ADDR_INT_ENABLE: rdata_nxt[EV_W-1:0] = int_enable_r;
			default:         rdata_nxt = 32'h0000_0000;
		endcase
	end

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			o_rdata <= i_rd ? rdata_nxt : 32'h0000_0000;
		end
	end

	assign input_good = (i_adapter_voltage >= uv_limit_r) &&
		(i_adapter_voltage <= ov_limit_r);
	assign input_high_impedance_state = ctrl_r[CTRL_IN_PIN_EN] && pin_r[SYNC_HIZ];

	assign charge_allowed_nxt = ctrl_r[CTRL_CHG_EN] &&
		(ctrl_r[CTRL_CE_DIS] || !pin_r[SYNC_CE]) &&
		!pin_r[SYNC_THERM] &&
		!input_high_impedance_state;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_charge_allowed             <= 1'b0;
			o_input_high_impedance_state <= 1'b0;
		end else begin
			o_charge_allowed             <= charge_allowed_nxt;
			o_input_high_impedance_state <= input_high_impedance_state;
		end
	end

	// Open-drain pins: an enable of 1 pulls the pin low.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_status_out_one_oe    <= 1'b0;
			o_status_out_two_oe    <= 1'b0;
			o_input_good_n_oe      <= 1'b0;
			o_charge_enable_pin_oe <= 1'b0;
		end else begin
			if (ctrl_r[CTRL_STAT_DIS]) begin
				o_status_out_one_oe <= force_on[0];
				o_status_out_two_oe <= force_on[1];
			end else begin
				o_status_out_one_oe <= i_charger_state[0];
				o_status_out_two_oe <= i_charger_state[1];
			end
			o_input_good_n_oe <= ctrl_r[CTRL_GOOD_DIS] ? force_on[2] : input_good;
			o_charge_enable_pin_oe <= ctrl_r[CTRL_CE_DIS] && force_on[3];
		end
	end

	assign o_status_out_one_o    = 1'b0;
	assign o_status_out_two_o    = 1'b0;
	assign o_input_good_n_o      = 1'b0;
	assign o_charge_enable_pin_o = 1'b0;
	assign o_host_alert_o        = 1'b0;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prev_state_r <= 2'h0;
			prev_good_r  <= 1'b0;
			prev_therm_r <= 1'b0;
			prev_hiz_r   <= 1'b0;
		end else begin
			prev_state_r <= i_charger_state;
			prev_good_r  <= input_good;
			prev_therm_r <= pin_r[SYNC_THERM];
			prev_hiz_r   <= input_high_impedance_state;
		end
	end

	// The state and input-good change detectors have no history in the first cycle after reset, so they take no event there.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			armed_r <= 1'b0;
		end else begin
			armed_r <= 1'b1;
		end
	end

	assign events[EV_STAT]  = armed_r && (i_charger_state != prev_state_r);
	assign events[EV_GOOD]  = armed_r && (input_good != prev_good_r);
	assign events[EV_THERM] = pin_r[SYNC_THERM] && !prev_therm_r;
	assign events[EV_HIZ]   = input_high_impedance_state && !prev_hiz_r;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(((int_status_r & ~int_clear) | events) & int_enable_r);
		end
	end

	csp_alert_if alert_bus ();

	assign alert_bus.trigger = |(events & int_enable_r);
	assign o_host_alert_oe   = alert_bus.active;

	csp_alert_pulse #(
		.P_CYCLES (P_ALERT_CYCLES)
	) u_alert (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.mp        (alert_bus.pulse)
	);

	// Charge limit from the resistor pin and the register field.
	csp_limit_sel #(
		.P_W (LIMIT_W)
	) u_chg_limit (
		.i_clk        (i_clk),
		.i_reset_n    (i_reset_n),
		.i_pin_enable (ctrl_r[CTRL_CHG_PIN_EN]),
		.i_pin_limit  (i_charge_limit_pin),
		.i_reg_limit  (chg_limit_r),
		.o_limit      (o_charge_limit)
	);

	// Input limit from the input pin and the register field.
	csp_limit_sel #(
		.P_W (LIMIT_W)
	) u_in_limit (
		.i_clk        (i_clk),
		.i_reset_n    (i_reset_n),
		.i_pin_enable (ctrl_r[CTRL_IN_PIN_EN]),
		.i_pin_limit  (i_input_limit_pin),
		.i_reg_limit  (in_limit_r),
		.o_limit      (o_input_limit)
	);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	a_alert_on_event: assert property (alert_bus.trigger && !alert_bus.active |=>
		o_host_alert_oe)
		else $error("Alert pulse did not start after an enabled event.");
	a_stat_code_out: assert property (!ctrl_r[CTRL_STAT_DIS] |=>
		{o_status_out_two_oe, o_status_out_one_oe} == $past(i_charger_state))
		else $error("Status pins do not show the charger state.");
	a_stat_force_out: assert property (ctrl_r[CTRL_STAT_DIS] |=>
		{o_status_out_two_oe, o_status_out_one_oe} == $past(force_on[1:0]))
		else $error("Disabled status pins do not follow their force bits.");
	a_input_good_win: assert property (!ctrl_r[CTRL_GOOD_DIS] |=>
		o_input_good_n_oe == ($past(i_adapter_voltage) >= $past(uv_limit_r) &&
		$past(i_adapter_voltage) <= $past(ov_limit_r)))
		else $error("Input-good pin disagrees with the voltage window.");
	a_input_good_force: assert property (ctrl_r[CTRL_GOOD_DIS] |=>
		o_input_good_n_oe == $past(force_on[2]))
		else $error("Disabled input-good pin does not follow its force bit.");
	a_charge_gate: assert property (o_charge_allowed |->
		$past(ctrl_r[CTRL_CHG_EN]) && !$past(pin_r[SYNC_THERM]) &&
		($past(ctrl_r[CTRL_CE_DIS]) || !$past(pin_r[SYNC_CE])))
		else $error("Charging allowed without its enables or with a thermistor fault.");
	a_ce_pin_ignored: assert property (ctrl_r[CTRL_CE_DIS] && ctrl_r[CTRL_CHG_EN] &&
		!pin_r[SYNC_THERM] && !input_high_impedance_state |=> o_charge_allowed)
		else $error("Charge enable pin still gates charging while disabled.");
	a_ce_indicator: assert property (##1 o_charge_enable_pin_oe ==
		($past(ctrl_r[CTRL_CE_DIS]) && $past(force_on[3])))
		else $error("Charge enable pin drive does not match its force bit.");
	a_hiz_entry: assert property (input_high_impedance_state |=> o_input_high_impedance_state &&
		!o_charge_allowed)
		else $error("High input pin did not force the high impedance state.");
	a_hiz_pin_off: assert property (!ctrl_r[CTRL_IN_PIN_EN] |=>
		!o_input_high_impedance_state)
		else $error("Input pin forced high impedance while disabled.");
	a_irq_level: assert property (##1 o_irq == |($past(int_status_r & ~int_clear | events) &
		$past(int_enable_r)))
		else $error("Interrupt output disagrees with enabled status.");
	a_status_set_wins: assert property ((|events) |=>
		(int_status_r & $past(events)) == $past(events))
		else $error("A status bit was not set by its event.");
	a_status_clear: assert property (int_clear[EV_STAT] && !events[EV_STAT] |=>
		!int_status_r[EV_STAT])
		else $error("A written clear left the status bit set.");
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
		else $error("Read data shown without a read strobe.");
	a_therm_suspend: assert property (pin_r[SYNC_THERM] |=> !o_charge_allowed)
		else $error("Charging allowed during a thermistor fault.");
	a_charge_bit_off: assert property (!ctrl_r[CTRL_CHG_EN] |=>
		!o_charge_allowed)
		else $error("Charging allowed with the enable bit clear.");
	a_ce_pin_gates: assert property (!ctrl_r[CTRL_CE_DIS] && pin_r[SYNC_CE] |=>
		!o_charge_allowed)
		else $error("Charging allowed with the enable pin high.");

	c_hiz_entry:    cover property (events[EV_HIZ] ##1 o_input_high_impedance_state);
	c_stat_forced:  cover property (ctrl_r[CTRL_STAT_DIS] && force_on[0] ##1 o_status_out_one_oe);
	c_alert_pulse:  cover property ($rose(o_host_alert_oe));
	c_charge_on:    cover property ($rose(o_charge_allowed));
	c_irq_raised:   cover property ($rose(o_irq));
endmodule : csp_status_pins

// ===== hdl/csp_pkg.sv
// Shared constants for the charger status pin logic.
package csp_pkg;
	localparam int unsigned CLK_FREQ_MHZ   = 20;
	localparam int unsigned ALERT_PULSE_US = 256;
	localparam int unsigned ALERT_PULSE_CYCLES = ALERT_PULSE_US * CLK_FREQ_MHZ;

	localparam int unsigned LIMIT_W = 8;
	localparam int unsigned VOLT_W  = 12;

	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_CHG_LIMIT  = 8'h04;
	localparam logic [7:0] ADDR_IN_LIMIT   = 8'h08;
	localparam logic [7:0] ADDR_UV_LIMIT   = 8'h0C;
	localparam logic [7:0] ADDR_OV_LIMIT   = 8'h10;
	localparam logic [7:0] ADDR_STATE      = 8'h14;
	localparam logic [7:0] ADDR_EFF_LIMITS = 8'h18;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_INT_CLEAR  = 8'h20;
	localparam logic [7:0] ADDR_INT_ENABLE = 8'h24;

	localparam int unsigned CTRL_CHG_EN      = 0;
	localparam int unsigned CTRL_STAT_DIS    = 1;
	localparam int unsigned CTRL_GOOD_DIS    = 2;
	localparam int unsigned CTRL_CE_DIS      = 3;
	localparam int unsigned CTRL_CHG_PIN_EN  = 4;
	localparam int unsigned CTRL_IN_PIN_EN   = 5;
	localparam int unsigned CTRL_FORCE_LSB   = 8;
	localparam int unsigned CTRL_W           = 12;
	localparam logic [11:0] CTRL_RST         = 12'h031;

	localparam logic [7:0]  CHG_LIMIT_RST = 8'hFF;
	localparam logic [7:0]  IN_LIMIT_RST  = 8'hFF;
	localparam logic [11:0] UV_LIMIT_RST  = 12'h000;
	localparam logic [11:0] OV_LIMIT_RST  = 12'hFFF;

	localparam int unsigned EV_STAT   = 0;
	localparam int unsigned EV_GOOD   = 1;
	localparam int unsigned EV_THERM  = 2;
	localparam int unsigned EV_HIZ    = 3;
	localparam int unsigned EV_W      = 4;
	localparam logic [3:0]  INT_EN_RST = 4'h0;

	localparam int unsigned SYNC_THERM = 0;
	localparam int unsigned SYNC_HIZ   = 1;
	localparam int unsigned SYNC_CE    = 2;
	localparam int unsigned SYNC_W     = 3;
	localparam logic [2:0]  SYNC_RST   = 3'h4;
endpackage : csp_pkg

// ===== hdl/csp_alert_if.sv
// Trigger and state of the host alert pulse between the controller and the pulse timer.
`timescale 1ns/1ps
interface csp_alert_if;
	logic trigger;
	logic active;
	modport pulse (input trigger, output active);
	modport ctrl  (output trigger, input active);
endinterface : csp_alert_if

// ===== hdl/csp_alert_pulse.sv
// Fixed-width host alert pulse timer with one pending retrigger.
`timescale 1ns/1ps
module csp_alert_pulse
	import csp_pkg::*;
#(
	parameter int unsigned P_CYCLES = ALERT_PULSE_CYCLES
) (
	input  wire logic   i_clk,
	input  wire logic   i_reset_n,
	csp_alert_if.pulse  mp
);
	localparam int unsigned CW = $clog2(P_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(P_CYCLES - 1);

	logic [CW-1:0] cnt_r;
	logic          pend_r;
	logic [CW-1:0] len_r;

	// An event during a pulse is kept and sent after one released cycle.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mp.active <= 1'b0;
			cnt_r     <= '0;
		end else if (!mp.active) begin
			if (mp.trigger || pend_r) begin
				mp.active <= 1'b1;
				cnt_r     <= '0;
			end
		end else if (cnt_r == LAST) begin
			mp.active <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pend_r <= 1'b0;
		end else if (mp.active && mp.trigger) begin
			pend_r <= 1'b1;
		end else if (!mp.active) begin
			pend_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			len_r <= '0;
		end else begin
			len_r <= mp.active ? len_r + 1'b1 : '0;
		end
	end

	a_alert_pulse_width: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$fell(mp.active) |-> $past(len_r) == LAST)
		else $error("Alert pulse width differs from the set count.");
endmodule : csp_alert_pulse

// ===== hdl/csp_limit_sel.sv
// Picks the lower of a pin limit and a register limit, or the register alone.
`timescale 1ns/1ps
module csp_limit_sel #(
	parameter int unsigned P_W = 8
) (
	input  wire logic           i_clk,
	input  wire logic           i_reset_n,
	input  wire logic           i_pin_enable,
	input  wire logic [P_W-1:0] i_pin_limit,
	input  wire logic [P_W-1:0] i_reg_limit,
	output logic      [P_W-1:0] o_limit
);
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_limit <= '0;
		end else if (i_pin_enable && (i_pin_limit < i_reg_limit)) begin
			o_limit <= i_pin_limit;
		end else begin
			o_limit <= i_reg_limit;
		end
	end

	a_limit_lower_pick: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_pin_enable |=> o_limit <= $past(i_reg_limit) && o_limit <= $past(i_pin_limit))
		else $error("Effective limit is above one of its sources.");
	a_limit_pin_ignored: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!i_pin_enable |=> o_limit == $past(i_reg_limit))
		else $error("Pin limit used while the pin is disabled.");
endmodule : csp_limit_sel

// ===== tb/csp_host_model.sv
// Host side of the pins: pull-up loads on the open-drain lines and the host drive of the enable pin.
`timescale 1ns/1ps
module csp_host_model (
	input  wire logic i_status_one_oe,
	input  wire logic i_status_two_oe,
	input  wire logic i_good_oe,
	input  wire logic i_alert_oe,
	input  wire logic i_ce_oe,
	input  wire logic i_ce_drive,
	input  wire logic i_ce_level,
	output logic      o_status_one_lvl,
	output logic      o_status_two_lvl,
	output logic      o_good_lvl,
	output logic      o_alert_lvl,
	output logic      o_ce_lvl
);
	// A released open-drain line reads high through its pull-up.
	assign o_status_one_lvl = ~i_status_one_oe;
	assign o_status_two_lvl = ~i_status_two_oe;
	assign o_good_lvl       = ~i_good_oe;
	assign o_alert_lvl      = ~i_alert_oe;
	// The host drives a definite level unless told to let go, so the pin never floats.
	assign o_ce_lvl = i_ce_oe ? 1'b0 : (i_ce_drive ? i_ce_level : 1'b1);
endmodule : csp_host_model

// ===== tb/tb_csp_status_pins.sv
// Self-checking bench for the charger status pin logic.
`timescale 1ns/1ps
module tb_csp_status_pins
	import csp_pkg::*;
;
	localparam int unsigned P_ALERT = 8;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic [7:0]         addr = 8'h00;
	logic [31:0]        wdata = 32'h0;
	logic               wr = 1'b0;
	logic               rd = 1'b0;
	logic [31:0]        rdata;
	logic [1:0]         state = 2'h0;
	logic [VOLT_W-1:0]  volt = 12'h150;
	logic               therm = 1'b0;
	logic [LIMIT_W-1:0] chg_pin = 8'hFF;
	logic [LIMIT_W-1:0] in_pin = 8'hFF;
	logic               pin_high = 1'b0;
	logic               ce_drive = 1'b1;
	logic               ce_level = 1'b0;
	logic               ce_lvl, ce_oe, s1_oe, s2_oe, g_oe, al_oe;
	logic               s1_lvl, s2_lvl, g_lvl, al_lvl;
	logic               irq, allowed, input_high_impedance_state;
	logic [LIMIT_W-1:0] chg_lim, in_lim;
	logic [4:0]         od_o;
	int                 bad_count = 0;
	int                 comparisons = 0;

	always #25 clk = ~clk;

	csp_status_pins #(.P_ALERT_CYCLES(P_ALERT)) csp_status_pins_inst (
		.i_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_charger_state(state), .i_adapter_voltage(volt),
		.i_thermistor_input_fault(therm), .i_charge_limit_pin(chg_pin),
		.i_input_limit_pin(in_pin), .i_input_limit_pin_high(pin_high),
		.i_charge_enable_pin_n(ce_lvl), .o_charge_enable_pin_o(od_o[0]),
		.o_charge_enable_pin_oe(ce_oe),
		.o_status_out_one_o(od_o[1]), .o_status_out_one_oe(s1_oe),
		.o_status_out_two_o(od_o[2]), .o_status_out_two_oe(s2_oe),
		.o_input_good_n_o(od_o[3]), .o_input_good_n_oe(g_oe),
		.o_host_alert_o(od_o[4]), .o_host_alert_oe(al_oe), .o_irq(irq),
		.o_charge_allowed(allowed),
		.o_input_high_impedance_state(input_high_impedance_state), .o_charge_limit(chg_lim), .o_input_limit(in_lim));

	csp_host_model csp_host_model_inst (
		.i_status_one_oe(s1_oe), .i_status_two_oe(s2_oe), .i_good_oe(g_oe),
		.i_alert_oe(al_oe), .i_ce_oe(ce_oe), .i_ce_drive(ce_drive), .i_ce_level(ce_level),
		.o_status_one_lvl(s1_lvl), .o_status_two_lvl(s2_lvl), .o_good_lvl(g_lvl),
		.o_alert_lvl(al_lvl), .o_ce_lvl(ce_lvl));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk

	task automatic wrap_up();
		if (bad_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	// Leaves room for the three-flop pin synchronisers and the registered outputs.
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask : settle

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_wr

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(name, rdata, e);
	endtask : rd_chk

	task automatic t_regs();
		rd_chk("ctrl reset", ADDR_CTRL, 32'h0000_0031);
		rd_chk("charge field reset", ADDR_CHG_LIMIT, 32'h0000_00FF);
		rd_chk("over limit reset", ADDR_OV_LIMIT, 32'h0000_0FFF);
		rd_chk("int enable reset", ADDR_INT_ENABLE, 32'h0);
		rd_chk("int status reset", ADDR_INT_STATUS, 32'h0);
		bus_wr(8'h28, 32'hFFFF_FFFF);
		rd_chk("unmapped read", 8'h28, 32'h0);
		rd_chk("clear reads zero", ADDR_INT_CLEAR, 32'h0);
	endtask : t_regs

	task automatic t_status();
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			state <= s[1:0];
			settle();
			chk("status one", {31'h0, s1_lvl}, {31'h0, ~s[0]});
			chk("status two", {31'h0, s2_lvl}, {31'h0, ~s[1]});
		end
		bus_wr(ADDR_CTRL, 32'h0000_0133);
		settle();
		chk("forced one", {31'h0, s1_lvl}, 32'h0);
		chk("free two", {31'h0, s2_lvl}, 32'h1);
		bus_wr(ADDR_CTRL, 32'h0000_0233);
		settle();
		chk("free one", {31'h0, s1_lvl}, 32'h1);
		chk("forced two", {31'h0, s2_lvl}, 32'h0);
		chk("open-drain data", {27'h0, od_o}, 32'h0);
		bus_wr(ADDR_CTRL, 32'h0000_0031);
	endtask : t_status

	task automatic t_good();
		logic [11:0] v[4] = '{12'h0FF, 12'h100, 12'h200, 12'h201};
		logic        e[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		bus_wr(ADDR_UV_LIMIT, 32'h100);
		bus_wr(ADDR_OV_LIMIT, 32'h200);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			volt <= v[i];
			settle();
			chk("input good", {31'h0, g_lvl}, {31'h0, e[i]});
		end
		bus_wr(ADDR_CTRL, 32'h0000_0435);
		settle();
		chk("good forced", {31'h0, g_lvl}, 32'h0);
		bus_wr(ADDR_CTRL, 32'h0000_0035);
		@(posedge clk);
		volt <= 12'h150;
		settle();
		chk("good released", {31'h0, g_lvl}, 32'h1);
		bus_wr(ADDR_CTRL, 32'h0000_0031);
	endtask : t_good

	task automatic t_charge();
		settle();
		chk("allowed", {31'h0, allowed}, 32'h1);
		rd_chk("state word", ADDR_STATE, 32'h0000_004E);
		@(posedge clk);
		ce_level <= 1'b1;
		settle();
		chk("pin high blocks", {31'h0, allowed}, 32'h0);
		@(posedge clk);
		ce_level <= 1'b0;
		bus_wr(ADDR_CTRL, 32'h0000_0030);
		settle();
		chk("bit low blocks", {31'h0, allowed}, 32'h0);
		bus_wr(ADDR_CTRL, 32'h0000_0039);
		ce_level <= 1'b1;
		settle();
		chk("pin ignored", {31'h0, allowed}, 32'h1);
		@(posedge clk);
		ce_drive <= 1'b0;
		bus_wr(ADDR_CTRL, 32'h0000_0839);
		settle();
		chk("ce forced", {30'h0, ce_oe, ce_lvl}, 32'h2);
		bus_wr(ADDR_CTRL, 32'h0000_0039);
		settle();
		chk("ce released", {30'h0, ce_oe, ce_lvl}, 32'h1);
		@(posedge clk);
		ce_drive <= 1'b1;
		ce_level <= 1'b0;
		bus_wr(ADDR_CTRL, 32'h0000_0031);
		therm <= 1'b1;
		settle();
		chk("therm suspends", {31'h0, allowed}, 32'h0);
		@(posedge clk);
		therm <= 1'b0;
		settle();
		chk("therm resumes", {31'h0, allowed}, 32'h1);
	endtask : t_charge

	task automatic t_limits();
		bus_wr(ADDR_CHG_LIMIT, 32'h40);
		bus_wr(ADDR_IN_LIMIT, 32'h60);
		chg_pin <= 8'h30;
		in_pin <= 8'h70;
		settle();
		chk("charge pin lower", {24'h0, chg_lim}, 32'h30);
		chk("input field lower", {24'h0, in_lim}, 32'h60);
		@(posedge clk);
		chg_pin <= 8'h50;
		in_pin <= 8'h20;
		settle();
		chk("charge field lower", {24'h0, chg_lim}, 32'h40);
		chk("input pin lower", {24'h0, in_lim}, 32'h20);
		rd_chk("effective limits", ADDR_EFF_LIMITS, 32'h0000_2040);
		bus_wr(ADDR_CTRL, 32'h0000_0001);
		chg_pin <= 8'h10;
		in_pin <= 8'h10;
		pin_high <= 1'b1;
		settle();
		chk("charge pin off", {24'h0, chg_lim}, 32'h40);
		chk("input pin off", {24'h0, in_lim}, 32'h60);
		chk("no forced hiz", {31'h0, input_high_impedance_state}, 32'h0);
		bus_wr(ADDR_CTRL, 32'h0000_0031);
		settle();
		chk("hiz entered", {30'h0, input_high_impedance_state, allowed}, 32'h2);
		@(posedge clk);
		pin_high <= 1'b0;
		settle();
		chk("hiz left", {31'h0, input_high_impedance_state}, 32'h0);
	endtask : t_limits

	task automatic t_irq();
		int n;
		bus_wr(ADDR_INT_CLEAR, 32'hF);
		bus_wr(ADDR_INT_ENABLE, 32'h1);
		settle();
		chk("irq idle", {31'h0, irq}, 32'h0);
		@(posedge clk);
		state <= state + 2'h1;
		n = 0;
		for (int i = 0; i < 10 && al_lvl === 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		while (al_lvl === 1'b0 && n < 20) begin
			n++;
			@(posedge clk);
			#1;
		end
		chk("alert pulse cycles", n, P_ALERT);
		chk("irq set", {31'h0, irq}, 32'h1);
		rd_chk("status bit", ADDR_INT_STATUS, 32'h1);
		bus_wr(ADDR_INT_CLEAR, 32'h1);
		bus_wr(ADDR_INT_ENABLE, 32'h0);
		settle();
		chk("irq cleared", {31'h0, irq}, 32'h0);
		@(posedge clk);
		state <= state + 2'h1;
		settle();
		chk("masked event", {30'h0, irq, al_lvl}, 32'h1);
		rd_chk("masked status", ADDR_INT_STATUS, 32'h1);
	endtask : t_irq

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_status();
		t_good();
		t_charge();
		t_limits();
		t_irq();
		wrap_up();
	end

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		wrap_up();
	end
endmodule : tb_csp_status_pins
